// ### fwr_pkg.sv
// Package: timing constants and enums for the flash write/reset host controller
package fwr_pkg;
  localparam int CLK_NS         = 50;
  localparam int WP_MIN_NS      = 60;
  localparam int WPH_MIN_NS     = 30;
  localparam int WHGL_MIN_NS    = 35;
  localparam int STS_LOW_MAX_NS = 500;
  localparam int RST_BUSY_NS    = 25000;
  localparam int RST_IDLE_NS    = 100;
  localparam int RST_DONE_NS    = 100;
  localparam int REC_32_NS      = 150;
  localparam int REC_64_NS      = 180;
  localparam int REC_128_NS     = 210;
  localparam int WP_CYC   = (WP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC  = (WPH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHGL_CYC = (WHGL_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STSW_CYC = (STS_LOW_MAX_NS / CLK_NS < 1) ? 1 : STS_LOW_MAX_NS / CLK_NS;
  localparam int RSTB_CYC = (RST_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTI_CYC = (RST_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTD_CYC = (RST_DONE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_32_CYC  = (REC_32_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_64_CYC  = (REC_64_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_128_CYC = (REC_128_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] DENS_32  = 2'h0;
  localparam logic [1:0] DENS_64  = 2'h1;
  localparam logic [1:0] DENS_128 = 2'h2;
  localparam logic [2:0] SEL_ON   = 3'h0;
  localparam logic [2:0] SEL_OFF  = 3'h1;
  localparam int OP_TMO_US = 1000000;
  localparam int ERS_SUSP_US = 500;
  localparam int CYC_PER_US  = 1000 / CLK_NS;
  // Wide enough for the full one-second operation timeout at this clock
  localparam int CW = 25;
  typedef enum logic [6:0] {
    FWR_RST   = 7'h01,
    FWR_REC   = 7'h02,
    FWR_IDLE  = 7'h04,
    FWR_WLOW  = 7'h08,
    FWR_WHIGH = 7'h10,
    FWR_READ  = 7'h20,
    FWR_BUSY  = 7'h40
  } fwr_state_e;
endpackage : fwr_pkg

// ### fwr_sync.sv
// Two-flop synchroniser for the ready/busy pin
`timescale 1ns/1ps
module fwr_sync (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);
  logic m_q;
  logic s_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      m_q <= 1'b1;
      s_q <= 1'b1;
    end else begin
      m_q <= din;
      s_q <= m_q;
    end
  end
  assign dout = s_q;
endmodule : fwr_sync

// ### fwr_host.sv
// Host controller: drives write strobe, chip selects, reset and program-enable of a parallel flash
`timescale 1ns/1ps
module fwr_host
  import fwr_pkg::*;
#(
  parameter logic [1:0] DENSITY = DENS_64,
  parameter int         TMO_CYC = OP_TMO_US * CYC_PER_US,
  parameter int         SUSP_CYC = ERS_SUSP_US * CYC_PER_US,
  parameter int         RSTB_CYCLES = RSTB_CYC
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic wr_req,
  input  wire logic wr_launch,
  input  wire logic wr_erase,
  input  wire logic wr_suspend,
  input  wire logic rd_req,
  input  wire logic reset_req,
  input  wire logic pe_release,
  output logic      wr_ready,
  output logic      rd_ready,
  output logic      op_busy,
  output logic      op_timeout,
  output logic      chip_select_a,
  output logic      chip_select_b,
  output logic      chip_select_c,
  output logic      write_strobe_n,
  output logic      output_enable_n,
  output logic      reset_powerdown_n,
  output logic      program_enable_supply,
  input  wire logic ready_busy_output
);
  fwr_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] susp_q, susp_d;
  logic          launch_q, launch_d;
  logic          sel_q, sel_d;
  logic          we_q, we_d;
  logic          oe_q, oe_d;
  logic          rp_q, rp_d;
  logic          pe_q, pe_d;
  logic          tmo_q, tmo_d;
  logic          rb_s;
  logic [CW-1:0] rec_cyc;

  fwr_sync u_rb (
    .mclk (mclk),
    .rstn (rstn),
    .din  (ready_busy_output),
    .dout (rb_s)
  );

  always_comb begin
    if (DENSITY == DENS_32)
      rec_cyc = CW'(REC_32_CYC);
    else if (DENSITY == DENS_64)
      rec_cyc = CW'(REC_64_CYC);
    else
      rec_cyc = CW'(REC_128_CYC);
  end

  always_comb begin
    st_d     = st_q;
    cnt_d    = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    susp_d   = (susp_q != '0) ? susp_q - 1'b1 : susp_q;
    launch_d = launch_q;
    sel_d    = sel_q;
    we_d     = we_q;
    oe_d     = oe_q;
    rp_d     = rp_q;
    pe_d     = pe_q;
    tmo_d    = tmo_q;
    case (st_q)
      FWR_RST: begin
        if (cnt_q == '0) begin
          rp_d  = 1'b1;
          cnt_d = rec_cyc;
          st_d  = FWR_REC;
        end
      end
      FWR_REC: begin
        if (cnt_q == '0)
          st_d = FWR_IDLE;
      end
      FWR_IDLE: begin
        if (reset_req) begin
          rp_d  = 1'b0;
          // After a timeout the device may still be busy, so it needs the long hold
          cnt_d = rb_s ? CW'(RSTI_CYC) : CW'(RSTB_CYCLES);
          st_d  = FWR_RST;
        end else if (wr_req && !(wr_suspend && susp_q != '0)) begin
          sel_d    = 1'b1;
          we_d     = 1'b1;
          oe_d     = 1'b0;
          pe_d     = 1'b1;
          launch_d = wr_launch;
          if (wr_erase)
            susp_d = CW'(SUSP_CYC);
          cnt_d    = CW'(WP_CYC);
          st_d     = FWR_WLOW;
        end else if (rd_req && cnt_q == '0) begin
          sel_d = 1'b1;
          oe_d  = 1'b1;
          st_d  = FWR_READ;
        end else if (pe_release && rb_s) begin
          pe_d = 1'b0;
        end
      end
      FWR_WLOW: begin
        if (cnt_q == CW'(1)) begin
          sel_d = 1'b0;
          we_d  = 1'b0;
          cnt_d = CW'((WPH_CYC > WHGL_CYC) ? WPH_CYC : WHGL_CYC);
          st_d  = FWR_WHIGH;
        end
      end
      FWR_WHIGH: begin
        if (cnt_q == '0) begin
          if (launch_q) begin
            cnt_d = CW'(TMO_CYC);
            tmo_d = 1'b0;
            st_d  = FWR_BUSY;
          end else begin
            st_d = FWR_IDLE;
          end
        end
      end
      FWR_READ: begin
        if (!rd_req) begin
          sel_d = 1'b0;
          oe_d  = 1'b0;
          st_d  = FWR_IDLE;
        end
      end
      FWR_BUSY: begin
        // Busy may not show for up to the launch delay, so hold off until it passes
        if (reset_req) begin
          rp_d  = 1'b0;
          cnt_d = CW'(RSTB_CYCLES);
          st_d  = FWR_RST;
        end else if (rb_s && cnt_q < CW'(TMO_CYC - STSW_CYC)) begin
          launch_d = 1'b0;
          // A leftover timeout count would otherwise stall the next read
          cnt_d    = '0;
          st_d     = FWR_IDLE;
        end else if (cnt_q == '0) begin
          tmo_d    = 1'b1;
          launch_d = 1'b0;
          st_d     = FWR_IDLE;
        end
      end
      default: st_d = FWR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= FWR_RST;
      cnt_q    <= CW'(RSTI_CYC);
      susp_q   <= '0;
      launch_q <= 1'b0;
      sel_q    <= 1'b0;
      we_q     <= 1'b0;
      oe_q     <= 1'b0;
      rp_q     <= 1'b0;
      pe_q     <= 1'b0;
      tmo_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      susp_q   <= susp_d;
      launch_q <= launch_d;
      sel_q    <= sel_d;
      we_q     <= we_d;
      oe_q     <= oe_d;
      rp_q     <= rp_d;
      pe_q     <= pe_d;
      tmo_q    <= tmo_d;
    end
  end

  // Selected drives a, b low and c low; deselect raises a only
  assign chip_select_a         = sel_q ? SEL_ON[0] : SEL_OFF[0];
  assign chip_select_b         = 1'b0;
  assign chip_select_c         = 1'b0;
  assign write_strobe_n        = ~we_q;
  assign output_enable_n       = ~oe_q;
  assign reset_powerdown_n     = rp_q;
  assign program_enable_supply = pe_q;
  assign wr_ready   = (st_q == FWR_IDLE) && !reset_req && !(wr_suspend && susp_q != '0);
  assign rd_ready   = (st_q == FWR_READ);
  assign op_busy    = (st_q == FWR_BUSY);
  assign op_timeout = tmo_q;

  a_no_rd_wr: assert property (@(posedge mclk) disable iff (!rstn)
    !(we_q && oe_q)) else $error("read and write strobes overlap");

  a_wp_width: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(we_q) |-> we_q[*2]) else $error("write pulse too short");

  a_wph_gap: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(we_q) |=> !we_q) else $error("write gap too short");

  a_rec_wait: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(rp_q) |-> !we_q[*4]) else $error("write during reset recovery");

  a_wr_rd_gap: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(we_q) |-> !oe_q) else $error("read right after write");

  a_rst_short: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(rp_q) |-> !rp_q[*2]) else $error("reset pulse too short");

  a_sel_write: assert property (@(posedge mclk) disable iff (!rstn)
    we_q |-> sel_q && !chip_select_a) else $error("write without select");

  a_pe_hold: assert property (@(posedge mclk) disable iff (!rstn)
    op_busy |-> pe_q) else $error("program enable dropped while busy");
endmodule : fwr_host

// ### fwr_flash_model.sv
// Behavioural flash device: ready/busy pin and host timing checks
`timescale 1ns/1ps
module fwr_flash_model #(
  parameter int REC_NS  = 180,
  parameter int RSTB_NS = 25000
) (
  input  wire logic        chip_select_a,
  input  wire logic        chip_select_b,
  input  wire logic        chip_select_c,
  input  wire logic        write_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        program_enable_supply,
  input  wire logic        launch,
  input  wire logic [31:0] op_ns,
  output logic             ready_busy_output,
  output logic [7:0]       viol
);
  logic    sel, wr, on, rst_busy;
  realtime t_dn, t_up, t_rp, t_rl, t_end;
  assign sel = (~chip_select_c & ~chip_select_b & ~chip_select_a)
             | (chip_select_c & ~(chip_select_a & chip_select_b));
  // Output enable wins over the strobe
  assign wr = sel & ~write_strobe_n & output_enable_n;
  initial begin
    viol = 8'h00;
    on = 1'b0;
    ready_busy_output = 1'b1;
    t_up = -1000;
    t_rl = 0;
    t_end = 0;
  end
  always @(posedge wr) if (wr === 1'b1 && reset_powerdown_n === 1'b1) begin
    if ($realtime - t_up < 30) viol++;
    if ($realtime - t_rp < REC_NS) viol++;
    t_dn = $realtime;
    on = 1'b1;
  end
  always @(negedge wr) if (on) begin
    on = 1'b0;
    if ($realtime - t_dn < 60) viol++;
    t_up = $realtime;
    if (launch) begin
      #200;
      ready_busy_output = ~reset_powerdown_n;
      t_end = $realtime + ((op_ns < 500) ? 500 : op_ns);
    end
  end
  always #10 if (!ready_busy_output && $realtime >= t_end) ready_busy_output = 1'b1;
  always @(negedge reset_powerdown_n) begin
    rst_busy = ~ready_busy_output;
    t_rl = $realtime;
    ready_busy_output = 1'b1;
  end
  always @(posedge reset_powerdown_n) begin
    if ($realtime - t_rl < (rst_busy ? RSTB_NS : 100)) viol++;
    t_rp = $realtime;
  end
  always @(negedge output_enable_n) if (sel === 1'b1 && $realtime - t_up < 35) viol++;
  always @(negedge write_strobe_n) if (output_enable_n === 1'b0) viol++;
  always @(negedge program_enable_supply) if (!ready_busy_output) viol++;
endmodule : fwr_flash_model

// ### fwr_host_test.sv
// Self-checking testbench for the flash write/reset host controller
`timescale 1ns/1ps
module fwr_host_test;
  import fwr_pkg::*;
  logic        mclk, rstn, wr_req, wr_launch, wr_erase, wr_suspend, rd_req, reset_req, pe_release;
  logic        wr_ready, rd_ready, op_busy, op_timeout, chip_select_a, chip_select_b, chip_select_c;
  logic        write_strobe_n, output_enable_n, reset_powerdown_n, program_enable_supply, ready_busy_output;
  logic [31:0] op_ns;
  logic [7:0]  viol;
  logic [5:0]  mon;
  int          fails, comparisons, n, m;
  // Rows: launch, erase, operation time in ns, expected busy
  logic [34:0] rows [3] = '{{2'h0, 32'h0, 1'b0}, {2'h2, 32'h258, 1'b1}, {2'h3, 32'h7D0, 1'b1}};
  localparam int SUSP_T = 20;
  assign mon = {reset_powerdown_n, write_strobe_n, op_timeout, op_busy, rd_ready, wr_ready};
  fwr_host #(.TMO_CYC(200), .SUSP_CYC(SUSP_T), .RSTB_CYCLES(10)) dut (
    .mclk, .rstn, .wr_req, .wr_launch, .wr_erase, .wr_suspend, .rd_req, .reset_req, .pe_release,
    .wr_ready, .rd_ready, .op_busy, .op_timeout, .chip_select_a, .chip_select_b, .chip_select_c,
    .write_strobe_n, .output_enable_n, .reset_powerdown_n, .program_enable_supply, .ready_busy_output);
  fwr_flash_model #(.REC_NS(REC_64_NS), .RSTB_NS(10 * CLK_NS)) fl (
    .chip_select_a, .chip_select_b, .chip_select_c, .write_strobe_n, .output_enable_n,
    .reset_powerdown_n, .program_enable_supply, .launch(wr_launch), .op_ns, .ready_busy_output, .viol);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h want %0h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wait_lvl(input int k, input logic v);
    n = 0;
    while (mon[k] !== v && n < 400) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_lvl
  task automatic wr(input logic l, input logic e);
    @(negedge mclk);
    wr_req = 1'b1;
    wr_launch = l;
    wr_erase = e;
    wait_lvl(4, 1'b0);
    wr_req = 1'b0;
    chk(chip_select_a, 1'b0, "select in pulse");
    m = 0;
    while (write_strobe_n === 1'b0 && m < 9) begin
      @(negedge mclk);
      m++;
    end
    chk(m, WP_CYC, "pulse width");
  endtask : wr
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    #(20000 * CLK_NS);
    fails++;
    end_of_test();
  end
  initial begin
    {rstn, wr_req, wr_launch, wr_erase, wr_suspend, rd_req, reset_req, pe_release} = 8'h00;
    op_ns = 32'h0;
    fails = 0;
    comparisons = 0;
    repeat (10) @(negedge mclk);
    chk({chip_select_a, write_strobe_n, output_enable_n, reset_powerdown_n, program_enable_supply}, 5'h1C, "reset");
    rstn = 1'b1;
    wait_lvl(0, 1'b1);
    chk(n >= 2 + REC_64_CYC, 1'b1, "recovery");
    $display("test reset done");
    foreach (rows[i]) begin
      op_ns = rows[i][32:1];
      wr(rows[i][34], rows[i][33]);
      repeat (3) @(negedge mclk);
      chk(op_busy, rows[i][0], "busy");
      wait_lvl(2, 1'b0);
      chk(op_timeout, 1'b0, "no timeout");
      $display("test row %0d done", i);
    end
    wr(1'b0, 1'b0);
    rd_req = 1'b1;
    wait_lvl(1, 1'b1);
    chk({output_enable_n, write_strobe_n}, 2'h1, "read strobes");
    rd_req = 1'b0;
    $display("test read done");
    wr(1'b0, 1'b1);
    wr_suspend = 1'b1;
    wait_lvl(0, 1'b1);
    chk(n >= SUSP_T - WP_CYC, 1'b1, "suspend hold-off");
    wr(1'b0, 1'b0);
    wr_suspend = 1'b0;
    $display("test suspend done");
    op_ns = 32'h186A0;
    wr(1'b1, 1'b0);
    wait_lvl(3, 1'b1);
    chk(op_timeout, 1'b1, "timeout");
    pe_release = 1'b1;
    repeat (3) @(negedge mclk);
    chk(program_enable_supply, 1'b1, "supply held");
    reset_req = 1'b1;
    wait_lvl(5, 1'b0);
    reset_req = 1'b0;
    wait_lvl(5, 1'b1);
    chk(n >= 9, 1'b1, "reset width");
    wait_lvl(0, 1'b1);
    repeat (3) @(negedge mclk);
    chk(program_enable_supply, 1'b0, "supply off");
    rstn = 1'b0;
    #1;
    chk({chip_select_a, write_strobe_n, output_enable_n, reset_powerdown_n}, 4'hE, "mid reset");
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    wait_lvl(0, 1'b1);
    chk(n >= 2 + REC_64_CYC, 1'b1, "mid recovery");
    $display("test mid reset done");
    chk(viol, 8'h00, "device timing");
    $display("test busy reset done");
    end_of_test();
  end
endmodule : fwr_host_test
